// ---- design/bbt_top.sv ----
// Bidirectional 18-bit bus transceiver datapath with AXI4-Lite status port
`timescale 1ns/1ps
`default_nettype none
`include "bbt_defines.svh"

module bbt_top
(
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    // AXI4-Lite slave
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [`BBT_ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    output logic [1:0]                   s_axi_bresp,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    input  wire logic [`BBT_ADDR_W-1:0]  s_axi_araddr,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    // Card-side A port
    input  wire bbt_pkg::bbt_word_t      a_data_in,
    output bbt_pkg::bbt_word_t           a_data_out,
    output logic                         a_data_oe,
    input  wire logic                    a_ext_drive,
    // Backplane-side B port
    input  wire bbt_pkg::bbt_word_t      b_data_in,
    output bbt_pkg::bbt_word_t           b_data_out,
    output logic                         b_data_oe,
    output logic                         b_fast_edge,
    // Direction controls
    input  wire logic                    a_to_b_drive_enable_n,
    input  wire logic                    b_to_a_drive_enable_n,
    input  wire logic                    a_to_b_transparent_ctl,
    input  wire logic                    b_to_a_transparent_ctl,
    input  wire logic                    a_to_b_capture_clock,
    input  wire logic                    b_to_a_capture_clock,
    input  wire logic                    a_to_b_capture_gate_n,
    input  wire logic                    b_to_a_capture_gate_n,
    input  wire logic                    edge_speed_select,
    // Snoop buffer fill-side ready
    output logic                         snoop_ready
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------

    logic [`BBT_PIN_W-1:0] pin_raw;
    logic [`BBT_PIN_W-1:0] pin_s1_q;
    logic [`BBT_PIN_W-1:0] pin_s2_q;

    // All pins gathered into one vector
    assign pin_raw = {edge_speed_select, a_ext_drive,
                      b_to_a_capture_gate_n, a_to_b_capture_gate_n,
                      b_to_a_capture_clock, a_to_b_capture_clock,
                      b_to_a_transparent_ctl, a_to_b_transparent_ctl,
                      b_to_a_drive_enable_n, a_to_b_drive_enable_n,
                      b_data_in, a_data_in};

    // Two-flop synchroniser
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end
        else
        begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
        end
    end

    bbt_pkg::bbt_word_t a_s;
    bbt_pkg::bbt_word_t b_s;
    logic [1:0]         drive_n_s;
    logic [1:0]         ctl_s;
    logic [1:0]         clk_s;
    logic [1:0]         gate_n_s;
    logic               ext_drive_s;
    logic               edge_s;

    // Synchronised pin fields
    assign a_s         = pin_s2_q[17:0];
    assign b_s         = pin_s2_q[35:18];
    assign drive_n_s   = pin_s2_q[37:36];
    assign ctl_s       = pin_s2_q[39:38];
    assign clk_s       = pin_s2_q[41:40];
    assign gate_n_s    = pin_s2_q[43:42];
    assign ext_drive_s = pin_s2_q[44];
    assign edge_s      = pin_s2_q[45];

    // ------------------------------------------------------------
    // A-port bus hold
    // ------------------------------------------------------------

    bbt_pkg::bbt_word_t a_hold_q;
    bbt_pkg::bbt_word_t a_level;
    bbt_pkg::bbt_word_t store_q [2];

    // Pin level: far driver, own driver, else held level
    assign a_level = ext_drive_s ? a_s : (a_data_oe ? store_q[bbt_pkg::BBT_DIR_BA] : a_hold_q);

    // Keeper follows whatever last drove the pin
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            a_hold_q <= '0;
        end
        else
        begin
            a_hold_q <= a_level;
        end
    end

    // ------------------------------------------------------------
    // Storage elements, one per direction
    // ------------------------------------------------------------

    bbt_pkg::bbt_word_t din [2];
    logic [1:0]         clk_d1_q;
    logic [1:0]         clk_rise;
    logic [1:0]         capture;

    // Next stored word from mode inputs
    function automatic bbt_pkg::bbt_word_t next_store(input logic ctl, input logic cap,
                                                     input bbt_pkg::bbt_word_t d,
                                                     input bbt_pkg::bbt_word_t q);
        return (ctl | cap) ? d : q;
    endfunction : next_store

    assign din[bbt_pkg::BBT_DIR_AB] = a_level;
    assign din[bbt_pkg::BBT_DIR_BA] = b_s;

    // Clock edge tracker
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            clk_d1_q <= 2'h0;
        end
        else
        begin
            clk_d1_q <= clk_s;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    genvar gd;
    generate
        for (gd = 0; gd < 2; gd++)
        begin : g_dir
            // Gated rising-edge capture, latch closed
            assign clk_rise[gd] = clk_s[gd] & ~clk_d1_q[gd];
            assign capture[gd]  = clk_rise[gd] & ~gate_n_s[gd] & ~ctl_s[gd];

            // Latch or flop, blind to drive enable
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    store_q[gd] <= '0;
                end
                else
                begin
                    store_q[gd] <= next_store(ctl_s[gd], capture[gd], din[gd], store_q[gd]);
                end
            end

            chk_transparent_follow: assert property (
                ctl_s[gd] |=> store_q[gd] == $past(din[gd]))
                else $error("transparent store does not follow input");

            chk_latched_hold: assert property (
                !ctl_s[gd] && !gate_n_s[gd] && !clk_rise[gd] |=> $stable(store_q[gd]))
                else $error("latched store changed without clock edge");

            chk_clock_capture: assert property (
                !ctl_s[gd] && !gate_n_s[gd] && clk_s[gd] && !$past(clk_s[gd])
                |=> store_q[gd] == $past(din[gd]))
                else $error("rising clock did not capture input");

            chk_clock_inhibit: assert property (
                !ctl_s[gd] && gate_n_s[gd] |=> $stable(store_q[gd]))
                else $error("inhibited clock changed store");

            chk_latch_close: assert property (
                $fell(ctl_s[gd]) && clk_s[gd] && $past(clk_s[gd]) ##1 !ctl_s[gd]
                |-> $stable(store_q[gd]))
                else $error("store changed after latch closed with clock high");

            chk_isolated_store: assert property (
                drive_n_s[gd] && ctl_s[gd] |=> store_q[gd] == $past(din[gd]))
                else $error("isolation disturbed storage");
        end
    endgenerate

    // ------------------------------------------------------------
    // Port drivers
    // ------------------------------------------------------------

    logic fast_q;

    // Edge speed follows synced select
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fast_q <= 1'h0;
        end
        else
        begin
            fast_q <= edge_s;
        end
    end

    // Outputs and enables
    assign b_data_out  = store_q[bbt_pkg::BBT_DIR_AB];
    assign a_data_out  = store_q[bbt_pkg::BBT_DIR_BA];
    assign b_data_oe   = ~drive_n_s[bbt_pkg::BBT_DIR_AB];
    assign a_data_oe   = ~drive_n_s[bbt_pkg::BBT_DIR_BA];
    assign b_fast_edge = fast_q;

    chk_isolation_ab: assert property (
        drive_n_s[bbt_pkg::BBT_DIR_AB] |-> !b_data_oe)
        else $error("B port driven while isolated");

    chk_edge_select: assert property (
        $past(edge_s) |-> b_fast_edge)
        else $error("fast edge not selected");

    chk_bus_hold: assert property (
        !ext_drive_s && !a_data_oe |=> a_hold_q == $past(a_hold_q))
        else $error("undriven A level moved");

    // ------------------------------------------------------------
    // Snoop buffer of A-to-B captures
    // ------------------------------------------------------------

    logic               ctrl_snoop_en_q;
    logic               snoop_valid;
    logic               snoop_pop;
    bbt_pkg::bbt_word_t snoop_data;

    bbt_skid_buf u_snoop
    (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_valid  (ctrl_snoop_en_q & capture[bbt_pkg::BBT_DIR_AB]),
        .in_ready  (snoop_ready),
        .in_data   (din[bbt_pkg::BBT_DIR_AB]),
        .out_valid (snoop_valid),
        .out_ready (snoop_pop),
        .out_data  (snoop_data)
    );

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------

    // Offset is one of the mapped registers
    function automatic logic is_mapped(input logic [`BBT_ADDR_W-1:0] addr);
        return (addr == `BBT_OFF_CTRL) || (addr == `BBT_OFF_STATUS) ||
               (addr == `BBT_OFF_AB_STORE) || (addr == `BBT_OFF_BA_STORE) ||
               (addr == `BBT_OFF_SNOOP);
    endfunction : is_mapped

    logic                   aw_held_q;
    logic                   w_held_q;
    logic [`BBT_ADDR_W-1:0] aw_addr_q;
    logic [31:0]            w_data_q;
    logic [3:0]             w_strb_q;
    logic                   bvalid_q;
    logic [1:0]             bresp_q;
    logic                   rvalid_q;
    logic [31:0]            rdata_q;
    logic [1:0]             rresp_q;
    logic                   do_write;
    logic                   ar_take;
    logic [31:0]            rd_word;

    // Channel handshakes
    assign s_axi_awready = ~aw_held_q & ~bvalid_q;
    assign s_axi_wready  = ~w_held_q & ~bvalid_q;
    assign s_axi_arready = ~rvalid_q;
    assign do_write      = aw_held_q & w_held_q & ~bvalid_q;
    assign ar_take       = s_axi_arvalid & s_axi_arready;
    assign snoop_pop     = ar_take & (s_axi_araddr == `BBT_OFF_SNOOP);
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // Read data selection
    assign rd_word =
        (s_axi_araddr == `BBT_OFF_CTRL)     ? {31'h0, ctrl_snoop_en_q} :
        (s_axi_araddr == `BBT_OFF_STATUS)   ? {30'h0, snoop_ready, snoop_valid} :
        (s_axi_araddr == `BBT_OFF_AB_STORE) ? {14'h0, store_q[bbt_pkg::BBT_DIR_AB]} :
        (s_axi_araddr == `BBT_OFF_BA_STORE) ? {14'h0, store_q[bbt_pkg::BBT_DIR_BA]} :
        (s_axi_araddr == `BBT_OFF_SNOOP)    ? {13'h0, snoop_valid, snoop_data} : 32'h0;

    // Write address and data capture, write response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q       <= 1'h0;
            w_held_q        <= 1'h0;
            aw_addr_q       <= '0;
            w_data_q        <= 32'h0;
            w_strb_q        <= 4'h0;
            bvalid_q        <= 1'h0;
            bresp_q         <= `BBT_RESP_OKAY;
            ctrl_snoop_en_q <= `BBT_CTRL_RESET;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_q <= 1'h1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_q <= 1'h1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held_q <= 1'h0;
                w_held_q  <= 1'h0;
                bvalid_q  <= 1'h1;
                bresp_q   <= is_mapped(aw_addr_q) ? `BBT_RESP_OKAY : `BBT_RESP_SLVERR;
                if (aw_addr_q == `BBT_OFF_CTRL && w_strb_q[0])
                begin
                    ctrl_snoop_en_q <= w_data_q[`BBT_CTRL_SNOOP_EN];
                end
            end
            else if (s_axi_bready)
            begin
                bvalid_q <= 1'h0;
            end
        end
    end

    // Read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'h0;
            rdata_q  <= 32'h0;
            rresp_q  <= `BBT_RESP_OKAY;
        end
        else if (ar_take)
        begin
            rvalid_q <= 1'h1;
            rdata_q  <= rd_word;
            rresp_q  <= is_mapped(s_axi_araddr) ? `BBT_RESP_OKAY : `BBT_RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            rvalid_q <= 1'h0;
        end
    end

endmodule : bbt_top

`default_nettype wire

// ---- inc/bbt_defines.svh ----
// Offsets, field positions, reset values and widths of the transceiver block
`ifndef BBT_DEFINES_SVH
`define BBT_DEFINES_SVH

`define BBT_DATA_W        18
`define BBT_ADDR_W        8
`define BBT_PIN_W         46

`define BBT_OFF_CTRL      8'h00
`define BBT_OFF_STATUS    8'h04
`define BBT_OFF_AB_STORE  8'h08
`define BBT_OFF_BA_STORE  8'h0c
`define BBT_OFF_SNOOP     8'h10

`define BBT_CTRL_SNOOP_EN 0
`define BBT_CTRL_RESET    1'h0
`define BBT_STAT_VALID    0
`define BBT_STAT_READY    1

`define BBT_RESP_OKAY     2'h0
`define BBT_RESP_SLVERR   2'h2

`endif

// ---- inc/bbt_pkg.sv ----
// Types shared by the transceiver block
package bbt_pkg;

    typedef logic [17:0] bbt_word_t;

    typedef enum logic
    {
        BBT_DIR_AB = 1'b0,
        BBT_DIR_BA = 1'b1
    } bbt_dir_t;

endpackage : bbt_pkg

// ---- design/bbt_skid_buf.sv ----
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
`include "bbt_defines.svh"

module bbt_skid_buf
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              in_valid,
    output logic                   in_ready,
    input  wire bbt_pkg::bbt_word_t in_data,
    output logic                   out_valid,
    input  wire logic              out_ready,
    output bbt_pkg::bbt_word_t     out_data
);

    bbt_pkg::bbt_word_t mem_q [2];
    logic               wr_ptr_q;
    logic               rd_ptr_q;
    logic [1:0]         count_q;
    logic               push;
    logic               pop;

    // Handshakes and flags
    assign in_ready  = (count_q != 2'h2);
    assign out_valid = (count_q != 2'h0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem_q[rd_ptr_q];

    // Storage
    always_ff @(posedge aclk)
    begin
        if (push)
        begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_ptr_q <= 1'h0;
            rd_ptr_q <= 1'h0;
            count_q  <= 2'h0;
        end
        else
        begin
            wr_ptr_q <= wr_ptr_q ^ push;
            rd_ptr_q <= rd_ptr_q ^ pop;
            count_q  <= count_q + {1'h0, push} - {1'h0, pop};
        end
    end

endmodule : bbt_skid_buf

`default_nettype wire

// ---- tb/bbt_far_side.sv ----
// Far-side model: card logic on the A pins, backplane on the B pins
`timescale 1ns/1ps
`default_nettype none

module bbt_far_side
(
    input  wire logic               aclk,
    input  wire logic               a_drv,
    input  wire bbt_pkg::bbt_word_t a_word,
    input  wire bbt_pkg::bbt_word_t b_word,
    output bbt_pkg::bbt_word_t      a_data_in,
    output logic                    a_ext_drive,
    output bbt_pkg::bbt_word_t      b_data_in
);
    // Known levels before the first edge
    initial
    begin
        a_data_in   = '0;
        a_ext_drive = 1'b0;
        b_data_in   = '0;
    end

    // Released A pins flip every cycle, so only bus hold keeps a level
    always @(posedge aclk)
    begin
        a_ext_drive <= a_drv;
        b_data_in   <= b_word;
        a_data_in   <= a_drv ? a_word : ~a_data_in;
    end
endmodule : bbt_far_side

`default_nettype wire

// ---- tb/bbt_tb_top.sv ----
// Self-checking testbench of the transceiver block
`timescale 1ns/1ps
`default_nettype none
`include "bbt_defines.svh"

module bbt_tb_top;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic               aclk = 1'b0;
    logic               aresetn = 1'b0;
    logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic               arvalid = 1'b0, rready = 1'b0;
    logic               awready, wready, bvalid, arready, rvalid;
    logic [7:0]         awaddr = 8'h00, araddr = 8'h00;
    logic [31:0]        wdata = 32'h0, rdata;
    logic [3:0]         wstrb = 4'h0;
    logic [1:0]         bresp, rresp;
    logic [1:0]         oen = 2'h3, ctl = 2'h0, cclk = 2'h3, gate = 2'h0;
    logic               esel = 1'b0, a_drv = 1'b0, smp = 1'b0;
    bbt_pkg::bbt_word_t a_word = '0, b_word = '0, a_in, b_in, a_out, b_out;
    logic               a_ext, a_oe, b_oe, fast, snoop_rdy;
    logic [31:0]        seed = 32'hd38bb6fb;
    int                 n_errors = 0, n_checks = 0;
    logic [33:0]        rd_q[$];
    logic [20:0]        pin_q[$];

    always #12.5 aclk = ~aclk;

    bbt_top dut_u
    (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .a_data_in(a_in), .a_data_out(a_out), .a_data_oe(a_oe), .a_ext_drive(a_ext),
        .b_data_in(b_in), .b_data_out(b_out), .b_data_oe(b_oe), .b_fast_edge(fast),
        .a_to_b_drive_enable_n(oen[0]), .b_to_a_drive_enable_n(oen[1]),
        .a_to_b_transparent_ctl(ctl[0]), .b_to_a_transparent_ctl(ctl[1]),
        .a_to_b_capture_clock(cclk[0]), .b_to_a_capture_clock(cclk[1]),
        .a_to_b_capture_gate_n(gate[0]), .b_to_a_capture_gate_n(gate[1]),
        .edge_speed_select(esel), .snoop_ready(snoop_rdy)
    );

    bbt_far_side far_u
    (
        .aclk(aclk), .a_drv(a_drv), .a_word(a_word), .b_word(b_word),
        .a_data_in(a_in), .a_ext_drive(a_ext), .b_data_in(b_in)
    );

    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wrap_up;
        if (n_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up

    // Monitor: oldest note against each read answer or pin sample
    always @(posedge aclk)
    begin
        logic [20:0] e;
        if (rvalid === 1'b1 && rready === 1'b1)
            chk({rresp, rdata}, rd_q.pop_front());
        if (smp === 1'b1)
        begin
            e = pin_q.pop_front();
            case (e[20:18])
                3'h0: chk({16'h0, b_out}, {16'h0, e[17:0]});
                3'h1: chk({16'h0, a_out}, {16'h0, e[17:0]});
                3'h2: chk({33'h0, b_oe}, {33'h0, e[0]});
                3'h3: chk({33'h0, a_oe}, {33'h0, e[0]});
                default: chk({33'h0, fast}, {33'h0, e[0]});
            endcase
        end
    end

    // ------------------------------------------------------------
    // Stimulus tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
    endfunction : lfsr

    task automatic wait_c(input int n);
        repeat (n) @(posedge aclk);
    endtask : wait_c

    task automatic expect_pin(input logic [2:0] k, input logic [17:0] v);
        pin_q.push_back({k, v});
        smp <= 1'b1;
        @(posedge aclk);
        smp <= 1'b0;
        @(posedge aclk);
    endtask : expect_pin

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done  = 1'b0;
        awvalid <= 1'b1;
        awaddr  <= a;
        wvalid  <= 1'b1;
        wdata   <= d;
        wstrb   <= 4'hf;
        bready  <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge aclk);
            if (!aw_done && awready === 1'b1)
            begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1)
            begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk({32'h0, bresp}, {32'h0, er});
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [33:0] exp);
        rd_q.push_back(exp);
        arvalid <= 1'b1;
        araddr  <= a;
        rready  <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1)
            @(posedge aclk);
        rready <= 1'b0;
    endtask : axi_rd

    task automatic set_src(input int d, input logic [17:0] w);
        if (d == 0)
            a_word <= w;
        else
            b_word <= w;
    endtask : set_src

    // One direction through transparent, latched, clocked, inhibit, isolation
    task automatic run_dir(input int d);
        logic [17:0] w0, w1, w2;
        seed = lfsr(seed); w0 = seed[17:0];
        seed = lfsr(seed); w1 = seed[17:0];
        seed = lfsr(seed); w2 = seed[17:0];
        oen[d] <= 1'b0;
        ctl[d] <= 1'b1;
        set_src(d, w0);
        wait_c(6);
        expect_pin(3'(d), w0);
        expect_pin(3'(d + 2), 18'h1);
        ctl[d] <= 1'b0;
        wait_c(4);
        set_src(d, w1);
        wait_c(6);
        expect_pin(3'(d), w0);
        cclk[d] <= 1'b0;
        wait_c(4);
        cclk[d] <= 1'b1;
        wait_c(6);
        expect_pin(3'(d), w1);
        gate[d] <= 1'b1;
        set_src(d, w2);
        cclk[d] <= 1'b0;
        wait_c(4);
        cclk[d] <= 1'b1;
        wait_c(6);
        expect_pin(3'(d), w1);
        gate[d] <= 1'b0;
        oen[d] <= 1'b1;
        ctl[d] <= 1'b1;
        wait_c(6);
        expect_pin(3'(d + 2), 18'h0);
        axi_rd(d ? `BBT_OFF_BA_STORE : `BBT_OFF_AB_STORE, {16'h0, w2});
        if (d == 0)
            axi_rd(`BBT_OFF_SNOOP, {15'h0, 1'b1, w1});
        if (d == 0)
            axi_rd(`BBT_OFF_STATUS, 34'h2);
        oen[d] <= 1'b0;
    endtask : run_dir

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        a_drv   <= 1'b1;
        wait_c(3);
        chk({33'h0, snoop_rdy}, 34'h1);
        axi_rd(`BBT_OFF_CTRL, 34'h0);
        axi_rd(8'h40, {`BBT_RESP_SLVERR, 32'h0});
        axi_wr(8'h44, 32'h1, `BBT_RESP_SLVERR);
        axi_wr(`BBT_OFF_CTRL, 32'h1, `BBT_RESP_OKAY);
        run_dir(0);
        run_dir(1);
        esel <= 1'b0;
        wait_c(6);
        expect_pin(3'h4, 18'h0);
        esel <= 1'b1;
        wait_c(6);
        expect_pin(3'h4, 18'h1);
        oen[1] <= 1'b1;
        seed = lfsr(seed);
        a_word <= seed[17:0];
        wait_c(6);
        expect_pin(3'h0, seed[17:0]);
        a_drv <= 1'b0;
        wait_c(8);
        expect_pin(3'h0, seed[17:0]);
        wrap_up();
    end

    // Cuts a hang short well beyond the expected run
    initial
    begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        wrap_up();
    end
endmodule : bbt_tb_top

`default_nettype wire
